// file: src/hpc_regs.sv
// Hub port configuration and status/command register bank
`timescale 1ns/100ps
module hpc_regs (
	input  wire logic                       clk,                  // Core clock, 10 MHz
	input  wire logic                       nrst,                 // External reset pin, active low
	input  wire logic                       wr_en,                // Register write strobe
	input  wire logic                       rd_en,                // Register read strobe
	input  wire logic [hpc_pkg::HPC_AW-1:0] addr,                 // Register offset
	input  wire logic [hpc_pkg::HPC_DW-1:0] wdata,                // Write data
	input  wire logic                       xfer_ack_done,        // Acknowledge of current transfer completed
	input  wire logic [2:0]                 pos_line,             // Logical D+ drive, upstream/port1/port2
	input  wire logic [2:0]                 neg_line,             // Logical D- drive, upstream/port1/port2
	output logic      [hpc_pkg::HPC_DW-1:0] rdata,                // Read data, registered
	output logic      [1:0]                 charge_port_enable,   // Charging enable, port 2 then port 1
	output logic      [1:0]                 upstream_drive_boost, // Upstream boost code
	output logic      [1:0]                 port1_drive_boost,    // Port 1 boost code
	output logic      [1:0]                 port2_drive_boost,    // Port 2 boost code
	output logic      [7:0]                 port_remap_ctrl,      // Remap control byte
	output logic                            usb_attach,           // Attach request toward upstream host
	output logic                            host_interface_sleep, // Host interface powered down
	output logic                            cfg_reset_pulse,      // Soft reset in progress
	output logic      [2:0]                 positive_line_pin,    // Physical positive pins, registered
	output logic      [2:0]                 negative_line_pin     // Physical negative pins, registered
);
	import hpc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic       rst_meta_ff, rst_sync_ff;
	logic       rst_n;
	logic [7:0] charge_ff, up_boost_ff, dn_boost_ff, swap_ff, remap_ff;
	logic       attach_ff, sleep_req_ff, sleep_ff, soft_rst_ff;
	logic [7:0] rdata_ff;
	logic [2:0] pos_pin_ff, neg_pin_ff;
	logic [2:0] pos_mux, neg_mux;

	// Reset pin released through two flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	assign rst_n = rst_sync_ff;

	////////////////////////////////////////////////////////////////////////
	// Write decode; a sleeping interface takes no further accesses
	wire bus_live    = !sleep_ff;
	wire wr_ok       = wr_en && bus_live;
	wire wr_cfg      = wr_ok && !attach_ff;
	wire wr_charge   = wr_cfg && (addr == HPC_OFS_CHARGE);
	wire wr_up_boost = wr_cfg && (addr == HPC_OFS_UP_BOOST);
	wire wr_dn_boost = wr_cfg && (addr == HPC_OFS_DN_BOOST);
	wire wr_swap     = wr_cfg && (addr == HPC_OFS_SWAP);
	wire wr_remap    = wr_cfg && (addr == HPC_OFS_REMAP);
	// Offset ff lies outside the protected range, so attach never locks it
	wire wr_stat     = wr_ok && (addr == HPC_OFS_STATCMD);
	wire soft_rst    = wr_stat && wdata[HPC_BIT_SOFT_RST];
	wire [7:0] nxt_charge   = wdata & HPC_MASK_CHARGE;
	wire [7:0] nxt_up_boost = wdata & HPC_MASK_UP_BOOST;
	wire [7:0] nxt_dn_boost = wdata & HPC_MASK_DN_BOOST;
	wire [7:0] nxt_swap     = wdata & HPC_MASK_SWAP;
	wire [7:0] nxt_remap    = wdata & HPC_MASK_REMAP;

	// Configuration registers: soft reset acts like the pin
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			charge_ff   <= HPC_RST_BYTE;
			up_boost_ff <= HPC_RST_BYTE;
			dn_boost_ff <= HPC_RST_BYTE;
			swap_ff     <= HPC_RST_BYTE;
			remap_ff    <= HPC_RST_BYTE;
		end else if (!rst_n || soft_rst_ff) begin
			charge_ff   <= HPC_RST_BYTE;
			up_boost_ff <= HPC_RST_BYTE;
			dn_boost_ff <= HPC_RST_BYTE;
			swap_ff     <= HPC_RST_BYTE;
			remap_ff    <= HPC_RST_BYTE;
		end else begin
			if (wr_charge)   charge_ff   <= nxt_charge;
			if (wr_up_boost) up_boost_ff <= nxt_up_boost;
			if (wr_dn_boost) dn_boost_ff <= nxt_dn_boost;
			if (wr_swap)     swap_ff     <= nxt_swap;
			if (wr_remap)    remap_ff    <= nxt_remap;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status/command. Write-once bits survive a soft reset: only the pin clears them.
	wire nxt_attach    = attach_ff || (wr_stat && wdata[HPC_BIT_ATTACH]);
	wire nxt_sleep_req = sleep_req_ff || (wr_stat && wdata[HPC_BIT_SLEEP]);
	wire nxt_sleep     = sleep_ff || (sleep_req_ff && xfer_ack_done);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			attach_ff    <= 1'b0;
			sleep_req_ff <= 1'b0;
			sleep_ff     <= 1'b0;
			soft_rst_ff  <= 1'b0;
		end else if (!rst_n) begin
			attach_ff    <= 1'b0;
			sleep_req_ff <= 1'b0;
			sleep_ff     <= 1'b0;
			soft_rst_ff  <= 1'b0;
		end else begin
			attach_ff    <= nxt_attach;
			sleep_req_ff <= nxt_sleep_req;
			sleep_ff     <= nxt_sleep;
			soft_rst_ff  <= soft_rst;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; soft reset bit is never shown set
	wire [7:0] stat_view = {5'h00, sleep_req_ff, 1'b0, attach_ff};
	wire [7:0] rd_mux = (addr == HPC_OFS_CHARGE)   ? charge_ff   :
	                    (addr == HPC_OFS_UP_BOOST) ? up_boost_ff :
	                    (addr == HPC_OFS_DN_BOOST) ? dn_boost_ff :
	                    (addr == HPC_OFS_SWAP)     ? swap_ff     :
	                    (addr == HPC_OFS_REMAP)    ? remap_ff    :
	                    (addr == HPC_OFS_STATCMD)  ? stat_view   : 8'h00;
	// Offsets that answer a read; any other offset reads as zero
	wire addr_hit = (addr == HPC_OFS_CHARGE)   || (addr == HPC_OFS_UP_BOOST) ||
	                (addr == HPC_OFS_DN_BOOST) || (addr == HPC_OFS_SWAP)     ||
	                (addr == HPC_OFS_REMAP)    || (addr == HPC_OFS_STATCMD);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= HPC_RST_BYTE;
		end else if (rd_en && bus_live) begin
			rdata_ff <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin swap, registered so outputs come from flops
	hpc_line_swap #(
		.N(3)
	) u_swap (
		.swap              (swap_ff[2:0]),
		.pos_line          (pos_line),
		.neg_line          (neg_line),
		.positive_line_pin (pos_mux),
		.negative_line_pin (neg_mux)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pos_pin_ff <= 3'h0;
			neg_pin_ff <= 3'h0;
		end else begin
			pos_pin_ff <= pos_mux;
			neg_pin_ff <= neg_mux;
		end
	end

	assign rdata                = rdata_ff;
	assign charge_port_enable   = {charge_ff[HPC_BIT_CHG_P2], charge_ff[HPC_BIT_CHG_P1]};
	assign upstream_drive_boost = up_boost_ff[HPC_BOOST_W-1:0];
	assign port1_drive_boost    = dn_boost_ff[HPC_BOOST_P1_LSB +: HPC_BOOST_W];
	assign port2_drive_boost    = dn_boost_ff[HPC_BOOST_P2_LSB +: HPC_BOOST_W];
	assign port_remap_ctrl      = remap_ff;
	assign usb_attach           = attach_ff;
	assign host_interface_sleep = sleep_ff;
	assign cfg_reset_pulse      = soft_rst_ff;
	assign positive_line_pin    = pos_pin_ff;
	assign negative_line_pin    = neg_pin_ff;

	////////////////////////////////////////////////////////////////////////
	// A soft reset may still clear locked registers, so it is kept out of the lock checks
	sequence s_locked_write;
		attach_ff && wr_en && !soft_rst_ff;
	endsequence

	sequence s_open_write;
		wr_en && !sleep_ff && !attach_ff && !soft_rst_ff;
	endsequence

	sequence s_stat_write;
		wr_en && !sleep_ff && (addr == HPC_OFS_STATCMD);
	endsequence

	sequence s_cfg_write_locked;
		s_locked_write ##0 (addr == HPC_OFS_CHARGE);
	endsequence

	a_attach_locks_cfg: assert property (@(posedge clk) disable iff (!rst_n)
		s_cfg_write_locked |=> $stable(charge_ff))
		else $error("charge register changed after attach");
	a_attach_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		attach_ff |=> attach_ff)
		else $error("attach bit cleared without pin reset");
	a_sleep_req_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_req_ff |=> sleep_req_ff)
		else $error("sleep request cleared without pin reset");
	a_sleep_after_ack: assert property (@(posedge clk) disable iff (!rst_n)
		(sleep_req_ff && xfer_ack_done) |=> sleep_ff)
		else $error("interface did not sleep after acknowledge");
	a_no_early_sleep: assert property (@(posedge clk) disable iff (!rst_n)
		(!sleep_ff && !(sleep_req_ff && xfer_ack_done)) |=> !sleep_ff)
		else $error("interface slept before acknowledge");
	a_soft_rst_clears: assert property (@(posedge clk) disable iff (!rst_n)
		soft_rst |=> ##1 (charge_ff == HPC_RST_BYTE && swap_ff == HPC_RST_BYTE && dn_boost_ff == HPC_RST_BYTE))
		else $error("soft reset left configuration set");
	a_soft_rst_hidden: assert property (@(posedge clk) disable iff (!rst_n)
		soft_rst_ff |=> !soft_rst_ff || $past(soft_rst))
		else $error("soft reset bit held set");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(charge_ff & ~HPC_MASK_CHARGE) == 8'h00 && (swap_ff & ~HPC_MASK_SWAP) == 8'h00)
		else $error("reserved bit stored");
	a_swap_pins: assert property (@(posedge clk) disable iff (!rst_n)
		swap_ff[HPC_BIT_SWP_UP] && $stable(swap_ff) |=> positive_line_pin[0] == $past(neg_line[0]))
		else $error("upstream pins not swapped");

	// Write protection after attach
	a_lock_up_boost: assert property (@(posedge clk) disable iff (!rst_n)
		s_locked_write ##0 (addr == HPC_OFS_UP_BOOST) |=> $stable(up_boost_ff))
		else $error("upstream boost changed after attach");
	a_lock_dn_boost: assert property (@(posedge clk) disable iff (!rst_n)
		s_locked_write ##0 (addr == HPC_OFS_DN_BOOST) |=> $stable(dn_boost_ff))
		else $error("downstream boost changed after attach");
	a_lock_swap: assert property (@(posedge clk) disable iff (!rst_n)
		s_locked_write ##0 (addr == HPC_OFS_SWAP) |=> $stable(swap_ff))
		else $error("swap register changed after attach");
	a_lock_remap: assert property (@(posedge clk) disable iff (!rst_n)
		s_locked_write ##0 (addr == HPC_OFS_REMAP) |=> $stable(remap_ff))
		else $error("remap register changed after attach");

	// Open writes land with reserved bits dropped
	a_charge_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_open_write ##0 (addr == HPC_OFS_CHARGE) |=> (charge_ff == ($past(wdata) & HPC_MASK_CHARGE)))
		else $error("charge register write wrong");
	a_charge_out: assert property (@(posedge clk) disable iff (!rst_n)
		s_open_write ##0 (addr == HPC_OFS_CHARGE) |=>
			(charge_port_enable == {$past(wdata[HPC_BIT_CHG_P2]), $past(wdata[HPC_BIT_CHG_P1])}))
		else $error("charge enables not on their ports");
	a_up_boost_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_open_write ##0 (addr == HPC_OFS_UP_BOOST) |=> (upstream_drive_boost == $past(wdata[HPC_BOOST_W-1:0])))
		else $error("upstream boost code wrong");
	a_dn_boost_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_open_write ##0 (addr == HPC_OFS_DN_BOOST) |=>
			(port2_drive_boost == $past(wdata[HPC_BOOST_P2_LSB +: HPC_BOOST_W])) &&
			(port1_drive_boost == $past(wdata[HPC_BOOST_P1_LSB +: HPC_BOOST_W])))
		else $error("downstream boost codes wrong");
	a_swap_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_open_write ##0 (addr == HPC_OFS_SWAP) |=> (swap_ff == ($past(wdata) & HPC_MASK_SWAP)))
		else $error("swap register write wrong");
	a_remap_write: assert property (@(posedge clk) disable iff (!rst_n)
		s_open_write ##0 (addr == HPC_OFS_REMAP) |=> (port_remap_ctrl == $past(wdata)))
		else $error("remap register write wrong");
	a_reserved_boost: assert property (@(posedge clk) disable iff (!rst_n)
		((up_boost_ff & ~HPC_MASK_UP_BOOST) == 8'h00) && ((dn_boost_ff & ~HPC_MASK_DN_BOOST) == 8'h00))
		else $error("reserved boost bit stored");

	// Status/command effects
	a_attach_set: assert property (@(posedge clk) disable iff (!rst_n)
		s_stat_write ##0 wdata[HPC_BIT_ATTACH] |=> usb_attach)
		else $error("attach not signalled");
	a_sleep_req_set: assert property (@(posedge clk) disable iff (!rst_n)
		s_stat_write ##0 wdata[HPC_BIT_SLEEP] |=> sleep_req_ff)
		else $error("sleep request not taken");
	a_sleep_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_ff |=> host_interface_sleep)
		else $error("interface woke without pin reset");

	// Soft reset
	a_soft_rst_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		soft_rst |=> cfg_reset_pulse)
		else $error("soft reset not started");
	a_soft_rst_rest: assert property (@(posedge clk) disable iff (!rst_n)
		soft_rst |=> ##1 (up_boost_ff == HPC_RST_BYTE && remap_ff == HPC_RST_BYTE))
		else $error("soft reset left boost or remap set");

	// Sleeping interface and read-back
	a_asleep_no_read: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_ff |=> $stable(rdata))
		else $error("read answered while asleep");
	a_asleep_no_write: assert property (@(posedge clk) disable iff (!rst_n)
		(sleep_ff && !soft_rst_ff) |=> $stable(charge_ff) && $stable(up_boost_ff) && $stable(dn_boost_ff) &&
			$stable(swap_ff) && $stable(remap_ff))
		else $error("write taken while asleep");
	a_stat_read: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_en && !sleep_ff && (addr == HPC_OFS_STATCMD)) |=>
			(rdata[HPC_BIT_SOFT_RST] == 1'b0) && (rdata[HPC_DW-1:HPC_BIT_SLEEP+1] == '0))
		else $error("status read shows reset or reserved bit");
	a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_en && !sleep_ff && !addr_hit) |=> (rdata == 8'h00))
		else $error("unmapped offset read nonzero");

	// Pin mapping per port
	a_straight_pins: assert property (@(posedge clk) disable iff (!rst_n)
		!swap_ff[HPC_BIT_SWP_P1] |=> (positive_line_pin[HPC_BIT_SWP_P1] == $past(pos_line[HPC_BIT_SWP_P1])))
		else $error("port 1 pins swapped while bit clear");
	a_swap_port2: assert property (@(posedge clk) disable iff (!rst_n)
		swap_ff[HPC_BIT_SWP_P2] |=> (negative_line_pin[HPC_BIT_SWP_P2] == $past(pos_line[HPC_BIT_SWP_P2])))
		else $error("port 2 pins not swapped");
endmodule // hpc_regs

// file: common/hpc_pkg.sv
// Package: offsets, field layouts and reset values of the hub port configuration bank
package hpc_pkg;
	localparam int          HPC_AW            = 8;
	localparam int          HPC_DW            = 8;
	localparam logic [7:0]  HPC_OFS_CHARGE    = 8'hd0;
	localparam logic [7:0]  HPC_OFS_UP_BOOST  = 8'hf6;
	localparam logic [7:0]  HPC_OFS_DN_BOOST  = 8'hf8;
	localparam logic [7:0]  HPC_OFS_SWAP      = 8'hfa;
	localparam logic [7:0]  HPC_OFS_REMAP     = 8'hfb;
	localparam logic [7:0]  HPC_OFS_STATCMD   = 8'hff;
	localparam logic [7:0]  HPC_RST_BYTE      = 8'h00;
	localparam logic [7:0]  HPC_MASK_CHARGE   = 8'h06;
	localparam logic [7:0]  HPC_MASK_UP_BOOST = 8'h03;
	localparam logic [7:0]  HPC_MASK_DN_BOOST = 8'h0f;
	localparam logic [7:0]  HPC_MASK_SWAP     = 8'h07;
	localparam logic [7:0]  HPC_MASK_REMAP    = 8'hff;
	localparam int          HPC_BIT_CHG_P1    = 1;
	localparam int          HPC_BIT_CHG_P2    = 2;
	localparam int          HPC_BIT_SWP_UP    = 0;
	localparam int          HPC_BIT_SWP_P1    = 1;
	localparam int          HPC_BIT_SWP_P2    = 2;
	localparam int          HPC_BIT_ATTACH    = 0;
	localparam int          HPC_BIT_SOFT_RST  = 1;
	localparam int          HPC_BIT_SLEEP     = 2;
	localparam int          HPC_BOOST_W       = 2;
	localparam int          HPC_BOOST_P1_LSB  = 0;
	localparam int          HPC_BOOST_P2_LSB  = 2;
	localparam logic [1:0]  HPC_BOOST_NORMAL  = 2'h0;
endpackage

// file: src/hpc_line_swap.sv
// Per-port line swap mux between logical D+/D- and the physical pins
`timescale 1ns/100ps
module hpc_line_swap #(
	parameter int N = 3
) (
	input  wire logic [N-1:0] swap,                // Per-port swap enable
	input  wire logic [N-1:0] pos_line,            // Logical positive line drive
	input  wire logic [N-1:0] neg_line,            // Logical negative line drive
	output logic      [N-1:0] positive_line_pin,   // Physical positive pin
	output logic      [N-1:0] negative_line_pin    // Physical negative pin
);
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_port
			assign positive_line_pin[g] = swap[g] ? neg_line[g] : pos_line[g];
			assign negative_line_pin[g] = swap[g] ? pos_line[g] : neg_line[g];
		end
	endgenerate
endmodule // hpc_line_swap

// file: dv/hpc_host_model.sv
// Host controller model: byte writes, byte reads and acknowledge pulses
`timescale 1ns/100ps
module hpc_host_model (
	input  wire logic       clk,           // Core clock
	output logic            wr_en,         // Write strobe
	output logic            rd_en,         // Read strobe
	output logic [7:0]      addr,          // Register offset
	output logic [7:0]      wdata,         // Write data
	output logic            xfer_ack_done, // Acknowledge finished
	input  wire logic [7:0] rdata          // Read data
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		xfer_ack_done = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Launched and ended on falling edges; idle lines are inverted so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		addr = ~a;
		d = rdata;
	endtask
	// Writes 01 to offset ff; the bench still writes configuration after it to check the lock
	task automatic attach();
		wr(8'hff, 8'h01);
	endtask
	task automatic ack();
		@(negedge clk);
		xfer_ack_done = 1'b1;
		@(negedge clk);
		xfer_ack_done = 1'b0;
	endtask
endmodule // hpc_host_model

// file: dv/hpc_regs_test.sv
// Self-checking bench for the hub port configuration register bank
`timescale 1ns/100ps
module hpc_regs_test;
	import hpc_pkg::*;
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic [2:0] pos_line = 3'h3;
	logic [2:0] neg_line = 3'h4;
	logic       wr_en, rd_en, xfer_ack_done, usb_attach, host_interface_sleep, cfg_reset_pulse;
	logic [7:0] addr, wdata, rdata, port_remap_ctrl, rd_val;
	logic [1:0] charge_port_enable, upstream_drive_boost, port1_drive_boost, port2_drive_boost;
	logic [2:0] positive_line_pin, negative_line_pin;
	int         fails = 0;
	int         n_tests = 0;
	int         cycles = 0;
	logic [7:0] ofs [5] = '{HPC_OFS_CHARGE, HPC_OFS_UP_BOOST, HPC_OFS_DN_BOOST, HPC_OFS_SWAP, HPC_OFS_REMAP};
	logic [7:0] msk [5] = '{HPC_MASK_CHARGE, HPC_MASK_UP_BOOST, HPC_MASK_DN_BOOST, HPC_MASK_SWAP, HPC_MASK_REMAP};
	hpc_host_model u_hpc_host_model (.clk, .wr_en, .rd_en, .addr, .wdata, .xfer_ack_done, .rdata);
	hpc_regs u_hpc_regs (.clk, .nrst, .wr_en, .rd_en, .addr, .wdata, .xfer_ack_done, .pos_line, .neg_line,
		.rdata, .charge_port_enable, .upstream_drive_boost, .port1_drive_boost, .port2_drive_boost,
		.port_remap_ctrl, .usb_attach, .host_interface_sleep, .cfg_reset_pulse, .positive_line_pin,
		.negative_line_pin);
	always #50 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (fails == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		u_hpc_host_model.rd(a, rd_val);
		chk("rdata", exp, rd_val);
	endtask
	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		for (int i = 0; i < 5; i++) rchk(ofs[i], HPC_RST_BYTE);
		rchk(HPC_OFS_STATCMD, HPC_RST_BYTE);
		chk("pos_pins", 8'h03, {5'h0, positive_line_pin});
		chk("neg_pins", 8'h04, {5'h0, negative_line_pin});
		u_hpc_host_model.ack();
		@(negedge clk);
		chk("sleep", 8'h00, {7'h0, host_interface_sleep});
		for (int i = 0; i < 5; i++) begin
			u_hpc_host_model.wr(ofs[i], 8'hff);
			rchk(ofs[i], msk[i]);
		end
		chk("charge", 8'h03, {6'h0, charge_port_enable});
		chk("remap", 8'hff, port_remap_ctrl);
		rchk(8'h40, 8'h00);
		for (int c = 0; c < 4; c++) begin
			u_hpc_host_model.wr(HPC_OFS_UP_BOOST, {6'h0, c[1:0]});
			u_hpc_host_model.wr(HPC_OFS_DN_BOOST, {4'h0, ~c[1:0], c[1:0]});
			chk("boost", {2'h0, c[1:0], ~c[1:0], c[1:0]},
				{2'h0, upstream_drive_boost, port2_drive_boost, port1_drive_boost});
		end
		u_hpc_host_model.wr(HPC_OFS_SWAP, 8'h05);
		repeat (2) @(negedge clk);
		chk("pos_pins", 8'h06, {5'h0, positive_line_pin});
		chk("neg_pins", 8'h01, {5'h0, negative_line_pin});
		pos_line = 3'h4;
		neg_line = 3'h3;
		repeat (2) @(negedge clk);
		chk("pos_pins", 8'h01, {5'h0, positive_line_pin});
		chk("neg_pins", 8'h06, {5'h0, negative_line_pin});
		u_hpc_host_model.wr(HPC_OFS_STATCMD, 8'h02);
		chk("reset_pulse", 8'h01, {7'h0, cfg_reset_pulse});
		repeat (3) @(negedge clk);
		chk("reset_pulse", 8'h00, {7'h0, cfg_reset_pulse});
		rchk(HPC_OFS_STATCMD, 8'h00);
		rchk(HPC_OFS_SWAP, 8'h00);
		chk("pos_pins", 8'h04, {5'h0, positive_line_pin});
		chk("remap", 8'h00, port_remap_ctrl);
		u_hpc_host_model.wr(HPC_OFS_CHARGE, 8'h02);
		u_hpc_host_model.attach();
		chk("attach", 8'h01, {7'h0, usb_attach});
		u_hpc_host_model.wr(HPC_OFS_CHARGE, 8'h04);
		rchk(HPC_OFS_CHARGE, 8'h02);
		u_hpc_host_model.wr(HPC_OFS_SWAP, 8'h02);
		u_hpc_host_model.wr(HPC_OFS_REMAP, 8'h5a);
		u_hpc_host_model.wr(HPC_OFS_UP_BOOST, 8'h03);
		u_hpc_host_model.wr(HPC_OFS_DN_BOOST, 8'h0f);
		rchk(HPC_OFS_SWAP, 8'h00);
		chk("remap", 8'h00, port_remap_ctrl);
		chk("boost", 8'h00, {2'h0, upstream_drive_boost, port2_drive_boost, port1_drive_boost});
		u_hpc_host_model.wr(HPC_OFS_STATCMD, 8'h02);
		repeat (3) @(negedge clk);
		chk("attach", 8'h01, {7'h0, usb_attach});
		u_hpc_host_model.wr(HPC_OFS_STATCMD, 8'h05);
		rchk(HPC_OFS_STATCMD, 8'h05);
		chk("sleep", 8'h00, {7'h0, host_interface_sleep});
		u_hpc_host_model.wr(HPC_OFS_STATCMD, 8'h00);
		rchk(HPC_OFS_STATCMD, 8'h05);
		u_hpc_host_model.ack();
		@(negedge clk);
		chk("sleep", 8'h01, {7'h0, host_interface_sleep});
		// Asleep: the read is dropped and the last answer stays
		rchk(HPC_OFS_CHARGE, 8'h05);
		nrst = 1'b0;
		@(negedge clk);
		chk("stat_bits", 8'h00, {6'h0, host_interface_sleep, usb_attach});
		close_out();
	end
endmodule // hpc_regs_test
